/* verilog/hps_pkg.sv */
/*
  Constants for the hub port status word: field positions, link state
  codes, speed codes, port state machine codes and reset values.
  Assumes a single 50 MHz controller clock domain.
*/
package hps_pkg;

  // Status word layout
  localparam int          HPS_WORD_W       = 16;
  localparam int          HPS_BIT_CONN     = 0;
  localparam int          HPS_BIT_ENABLE   = 1;
  localparam int          HPS_BIT_OVC      = 3;
  localparam int          HPS_BIT_RESET    = 4;
  localparam int          HPS_LINK_LSB     = 5;
  localparam int          HPS_LINK_W       = 4;
  localparam int          HPS_BIT_POWER    = 9;
  localparam int          HPS_SPEED_LSB    = 10;
  localparam int          HPS_SPEED_W      = 3;
  localparam int          HPS_RSVD_LSB     = 13;
  localparam int          HPS_RSVD_W       = 3;
  localparam logic [15:0] HPS_WORD_RESET   = 16'h0000;

  // Link state codes
  localparam logic [3:0]  HPS_LINK_U0        = 4'h0;
  localparam logic [3:0]  HPS_LINK_U1        = 4'h1;
  localparam logic [3:0]  HPS_LINK_U2        = 4'h2;
  localparam logic [3:0]  HPS_LINK_U3        = 4'h3;
  localparam logic [3:0]  HPS_LINK_DISABLED  = 4'h4;
  localparam logic [3:0]  HPS_LINK_RXDETECT  = 4'h5;
  localparam logic [3:0]  HPS_LINK_INACTIVE  = 4'h6;
  localparam logic [3:0]  HPS_LINK_POLLING   = 4'h7;
  localparam logic [3:0]  HPS_LINK_RECOVERY  = 4'h8;
  localparam logic [3:0]  HPS_LINK_HOTRESET  = 4'h9;
  localparam logic [3:0]  HPS_LINK_COMPLY    = 4'ha;
  localparam logic [3:0]  HPS_LINK_LOOPBACK  = 4'hb;
  localparam logic [3:0]  HPS_LINK_RESET_VAL = HPS_LINK_RXDETECT;

  // Speed code and reserved field value
  localparam logic [2:0]  HPS_SPEED_ENH    = 3'h0;
  localparam logic [2:0]  HPS_RSVD_VAL     = 3'h0;

  // Downstream port states, one-hot
  typedef enum logic [3:0] {
    HPS_PORT_OFF       = 4'h1,
    HPS_PORT_IDLE      = 4'h2,
    HPS_PORT_RESETTING = 4'h4,
    HPS_PORT_ENABLED   = 4'h8
  } hps_port_state_t;

endpackage : hps_pkg

/* verilog/hps_sync.sv */
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ps
module hps_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages, only the second is visible
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : hps_sync

/* verilog/hps_port_status.sv */
/*
  Hub downstream port status word assembler with a small port state
  machine for power, reset signalling and enable.
  The word carries the connection and enable bits, the over-current bit,
  the reset flag, the latched link state, the logical power bit, the
  speed code and the reserved top bits. A status read returns the word
  in the low half of the reply and the change word in the high half.
  A host request shows in the state one edge after it is taken and in
  the word one edge later; an over-current pin change needs three edges to show, a connect pin change four while the port is off or idle.
  Assumes pin-level status inputs are asynchronous and pass a synchroniser;
  host requests arrive as one-cycle pulses from the request decoder on
  this clock; the link state and its done strobe come from the link
  layer on this clock; the change word is kept by other logic on this
  clock and is only sampled on a read.
*/
//
// Summary of operation
// - Over-current bit follows present over-current condition
// - Reset flag sets on host reset request while powered
// - Reset flag holds until reset signalling stops
// - Link state shown in bits five to eight
// - Link field updates only after transition completes
// - U0 to U3 encode as zero to three
// - Disabled, receiver detect, inactive encode four to six
// - Polling, recovery, hot reset encode seven to nine
// - Compliance, loopback A, B; never C to F
// - Power bit zero only when powered off
// - Power bit is logical, not supply switch
// - Speed field bits ten to twelve
// - Speed code zero only; others reserved
// - Status word is first returned word
// - Reset flag clear outside resetting state
`timescale 1ns/1ps
module hps_port_status
  import hps_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        ovc_pin_in,
  input  wire logic        connect_pin_in,
  input  wire logic [3:0]  link_state_in,
  input  wire logic        link_trans_done_in,
  input  wire logic        set_power_req_in,
  input  wire logic        clr_power_req_in,
  input  wire logic        set_reset_req_in,
  input  wire logic        reset_sig_done_in,
  input  wire logic        status_rd_in,
  input  wire logic [15:0] change_word_in,
  output logic [15:0]      port_status_word_out,
  output logic [31:0]      status_data_out,
  output logic             status_valid_out,
  output logic             reset_signal_out
);

  // Synchronised pins, port state and output registers
  logic [1:0]      pin_sync;
  logic            ovc_s;
  logic            conn_s;
  hps_port_state_t port_ff, nxt_port;
  logic [3:0]      link_ff, nxt_link;
  logic            conn_ff, nxt_conn;
  logic [15:0]     word_ff, nxt_word;
  logic [31:0]     data_ff, nxt_data;
  logic            valid_ff, nxt_valid;
  logic            rsig_ff, nxt_rsig;
  logic [15:0]     word_c;

  // Reserved link codes are refused, so the field keeps its last legal value
  function automatic logic link_code_legal(input logic [3:0] code);
    link_code_legal = (code <= HPS_LINK_LOOPBACK);
  endfunction : link_code_legal

  // Port state decodes shared by the word, the connect latch and the output
  function automatic logic port_powered(input hps_port_state_t st);
    port_powered = (st != HPS_PORT_OFF);
  endfunction : port_powered

  function automatic logic port_resetting(input hps_port_state_t st);
    port_resetting = (st == HPS_PORT_RESETTING);
  endfunction : port_resetting

  function automatic logic port_enabled(input hps_port_state_t st);
    port_enabled = (st == HPS_PORT_ENABLED);
  endfunction : port_enabled

  // Place each field at its bit position; every other bit reads zero
  function automatic logic [15:0] pack_status(
    input logic       conn,
    input logic       enabled,
    input logic       ovc,
    input logic       resetting,
    input logic [3:0] link,
    input logic       powered
  );
    logic [15:0] w;
    w = HPS_WORD_RESET;
    w[HPS_BIT_CONN]   = conn;
    w[HPS_BIT_ENABLE] = enabled;
    w[HPS_BIT_OVC]    = ovc;
    w[HPS_BIT_RESET]  = resetting;
    w[HPS_LINK_LSB +: HPS_LINK_W]   = link;
    w[HPS_BIT_POWER]  = powered;
    w[HPS_SPEED_LSB +: HPS_SPEED_W] = HPS_SPEED_ENH;
    w[HPS_RSVD_LSB +: HPS_RSVD_W]   = HPS_RSVD_VAL;
    pack_status = w;
  endfunction : pack_status

  // Pin inputs pass two flops
  hps_sync #(.W(2)) u_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   ({connect_pin_in, ovc_pin_in}),
    .sync_out   (pin_sync)
  );
  assign ovc_s  = pin_sync[0];
  assign conn_s = pin_sync[1];

  // Port state machine and latched link state
  always_comb begin
    nxt_port = port_ff;
    nxt_link = link_ff;
    nxt_conn = conn_ff;
    // Clearing power wins over every other request except a set power request in the off state
    unique case (port_ff)
      HPS_PORT_OFF: begin
        if (set_power_req_in) begin
          nxt_port = HPS_PORT_IDLE;
        end
      end
      HPS_PORT_IDLE: begin
        if (clr_power_req_in) begin
          nxt_port = HPS_PORT_OFF;
        end else if (set_reset_req_in) begin
          nxt_port = HPS_PORT_RESETTING;
        end
      end
      HPS_PORT_RESETTING: begin
        if (clr_power_req_in) begin
          nxt_port = HPS_PORT_OFF;
        end else if (reset_sig_done_in) begin
          nxt_port = conn_s ? HPS_PORT_ENABLED : HPS_PORT_IDLE;
        end
      end
      HPS_PORT_ENABLED: begin
        if (clr_power_req_in) begin
          nxt_port = HPS_PORT_OFF;
        end else if (set_reset_req_in) begin
          nxt_port = HPS_PORT_RESETTING;
        end else if (!conn_s) begin
          nxt_port = HPS_PORT_IDLE;
        end
      end
      default: begin
        nxt_port = HPS_PORT_OFF;
      end
    endcase
    // Connection held through resetting, set when enabled
    if (port_enabled(port_ff)) begin
      nxt_conn = 1'b1;
    end else if (!port_resetting(port_ff)) begin
      nxt_conn = conn_s;
    end
    // Capture link state only on completed transition
    // A mid-transition code never reaches the field
    if (link_trans_done_in && link_code_legal(link_state_in)) begin
      nxt_link = link_state_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_ff <= HPS_PORT_OFF;
      link_ff <= HPS_LINK_RESET_VAL;
      conn_ff <= 1'b0;
    end else begin
      port_ff <= nxt_port;
      link_ff <= nxt_link;
      conn_ff <= nxt_conn;
    end
  end

  // Assemble the status word from the registered state
  always_comb begin
    word_c = pack_status(conn_ff, port_enabled(port_ff), ovc_s,
                         port_resetting(port_ff), link_ff, port_powered(port_ff));
  end

  // Registered outputs and status read reply
  // Reset signalling follows the next state, one edge ahead of the flag
  always_comb begin
    nxt_word  = word_c;
    nxt_rsig  = port_resetting(nxt_port);
    nxt_valid = status_rd_in;
    nxt_data  = data_ff;
    if (status_rd_in) begin
      nxt_data = {change_word_in, word_c};
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_ff  <= HPS_WORD_RESET;
      data_ff  <= 32'h0000_0000;
      valid_ff <= 1'b0;
      rsig_ff  <= 1'b0;
    end else begin
      word_ff  <= nxt_word;
      data_ff  <= nxt_data;
      valid_ff <= nxt_valid;
      rsig_ff  <= nxt_rsig;
    end
  end

  assign port_status_word_out = word_ff;
  assign status_data_out      = data_ff;
  assign status_valid_out     = valid_ff;
  assign reset_signal_out     = rsig_ff;

endmodule : hps_port_status

/* test/hps_port_status_sva.sv */
/* Timing checks on the port status word outputs.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module hps_port_status_sva (
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic        ovc_pin_in,
  input wire logic [3:0]  link_state_in,
  input wire logic        link_trans_done_in,
  input wire logic        clr_power_req_in,
  input wire logic        reset_sig_done_in,
  input wire logic [15:0] port_status_word_out,
  input wire logic [31:0] status_data_out,
  input wire logic        status_valid_out,
  input wire logic        reset_signal_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Accepted link code
  sequence s_link_take;
    link_trans_done_in && (link_state_in <= 4'hb);
  endsequence
  // Over-current pin held long enough to cross the synchroniser
  sequence s_ovc_high;
    ovc_pin_in [*5];
  endsequence
  sequence s_ovc_low;
    !ovc_pin_in [*5];
  endsequence
  // Field relations
  chk_ovc_follow: assert property (s_ovc_high |-> port_status_word_out[3])
    else $error("ovc bit low with pin high");
  chk_ovc_clear: assert property (s_ovc_low |-> !port_status_word_out[3])
    else $error("ovc bit high with pin low");
  chk_rst_flag: assert property (port_status_word_out[4] == $past(reset_signal_out))
    else $error("reset flag differs from signalling");
  chk_rst_hold: assert property ($fell(reset_signal_out) |->
    $past(reset_sig_done_in) || $past(clr_power_req_in))
    else $error("reset signalling dropped early");
  chk_link_take: assert property (s_link_take |-> ##2
    port_status_word_out[8:5] == $past(link_state_in, 2)) else $error("link field wrong");
  chk_link_hold: assert property (($past(reset_n_in, 2) &&
    $changed(port_status_word_out[8:5])) |-> $past(link_trans_done_in, 2))
    else $error("link field moved without done");
  chk_link_legal: assert property (port_status_word_out[8:5] <= 4'hb)
    else $error("reserved link code");
  chk_upper_zero: assert property (port_status_word_out[15:10] == 6'h00)
    else $error("speed or reserved bits set");
  chk_power_off: assert property (clr_power_req_in |-> ##2 !port_status_word_out[9])
    else $error("power bit stuck");
  chk_data_word: assert property ((status_valid_out && $stable(port_status_word_out))
    |-> status_data_out[15:0] == port_status_word_out) else $error("status not first");
endmodule : hps_port_status_sva
bind hps_port_status hps_port_status_sva u_sva (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .ovc_pin_in(ovc_pin_in), .link_state_in(link_state_in),
  .link_trans_done_in(link_trans_done_in), .clr_power_req_in(clr_power_req_in),
  .reset_sig_done_in(reset_sig_done_in), .port_status_word_out(port_status_word_out),
  .status_data_out(status_data_out), .status_valid_out(status_valid_out),
  .reset_signal_out(reset_signal_out));

/* test/hps_host_model.sv */
/* Host side: issues status requests and takes the answer.
   Assumes the answer comes within a few cycles of the request. */
`timescale 1ns/1ps
module hps_host_model (
  input  wire logic        clock_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] data_in,
  output logic             rd_out
);
  initial rd_out = 1'b0;
  // One request pulse; ok stays low if no answer within eight edges
  task automatic get_status(output logic [31:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clock_in) rd_out <= 1'b1;
    @(posedge clock_in) rd_out <= 1'b0;
    while (valid_in !== 1'b1 && n < 8) begin
      @(posedge clock_in);
      n++;
    end
    ok = (valid_in === 1'b1);
    d = data_in;
  endtask : get_status
endmodule : hps_host_model

/* test/hps_port_status_tb.sv */
/* Sequence tests of the port status word.
   Assumes the design and the host model on one 50 MHz clock. */
`timescale 1ns/1ps
module hps_port_status_tb;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ovc = 1'b0;
  logic [4:0]  req = 5'h00; // Done, set pwr, clr pwr, set rst, rst done
  logic [3:0]  link = 4'h0;
  logic [15:0] chg = 16'ha5c3;
  logic        conn = 1'b0;
  logic [3:0]  exp_link;
  logic        rd, valid, rsig;
  logic [15:0] word;
  logic [31:0] data, got;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #10 clock_in = ~clock_in;
  hps_port_status u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .ovc_pin_in(ovc),
    .connect_pin_in(conn), .link_state_in(link), .link_trans_done_in(req[0]),
    .set_power_req_in(req[1]), .clr_power_req_in(req[2]), .set_reset_req_in(req[3]),
    .reset_sig_done_in(req[4]), .status_rd_in(rd), .change_word_in(chg),
    .port_status_word_out(word), .status_data_out(data), .status_valid_out(valid),
    .reset_signal_out(rsig));
  hps_host_model u_host (.clock_in(clock_in), .valid_in(valid), .data_in(data), .rd_out(rd));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One-cycle request, then settle
  task automatic pulse(input int i);
    @(posedge clock_in) req[i] <= 1'b1;
    @(posedge clock_in) req[i] <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : pulse
  // Status read; a missing answer ends the run
  task automatic rd_word(input logic [15:0] e);
    logic ok;
    u_host.get_status(got, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH status_valid exp 1 got %b", ok);
      final_report();
    end else begin
      chk("word", e, got[15:0]);
      chk("change", chg, got[31:16]);
      chk("status_word", e, word);
      chk("reset_signal", {15'h0000, e[4]}, {15'h0000, rsig});
    end
  endtask : rd_word
  // Expected word: connect, enable, over-current, reset, link, power
  function automatic logic [15:0] ew(logic c, logic n, logic o, logic r, logic [3:0] l,
                                     logic p);
    return {6'h00, p, l, r, o, 1'b0, n, c};
  endfunction : ew
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 1'b0));
    for (int k = 0; k < 16; k++) begin
      link <= k[3:0];
      exp_link = (k < 12) ? k[3:0] : 4'hb;
      pulse(0);
      rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, exp_link, 1'b0));
    end
    link <= 4'h3;
    repeat (4) @(posedge clock_in);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b0));
    ovc <= 1'b1;
    repeat (6) @(posedge clock_in);
    rd_word(ew(1'b0, 1'b0, 1'b1, 1'b0, 4'hb, 1'b0));
    ovc <= 1'b0;
    repeat (6) @(posedge clock_in);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b0));
    pulse(3);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b0));
    pulse(1);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b1));
    pulse(3);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b1, 4'hb, 1'b1));
    repeat (20) @(posedge clock_in);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b1, 4'hb, 1'b1));
    pulse(4);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b1));
    pulse(2);
    rd_word(ew(1'b0, 1'b0, 1'b0, 1'b0, 4'hb, 1'b0));
    conn <= 1'b1;
    pulse(1);
    rd_word(ew(1'b1, 1'b0, 1'b0, 1'b0, 4'hb, 1'b1));
    pulse(3);
    rd_word(ew(1'b1, 1'b0, 1'b0, 1'b1, 4'hb, 1'b1));
    pulse(4);
    rd_word(ew(1'b1, 1'b1, 1'b0, 1'b0, 4'hb, 1'b1));
    pulse(2);
    rd_word(ew(1'b1, 1'b0, 1'b0, 1'b0, 4'hb, 1'b0));
    final_report();
  end
endmodule : hps_port_status_tb
